/* pkg/dpc_map.svh */
/*
 * Constants of the defect pixel table corrector: sizes, encodings, factory list.
 * Assumes it is included by bare name from the package and the design modules.
 */
// Overview of operation
// RULE1: The block keeps an entry count of table entries that the host can write and read back.
// RULE2: Entries are addressed by a zero-based select running from 0 to count minus one.
// RULE3: Column and row of the selected entry are readable and writable by the host.
// RULE4: Coordinates are those of the full sensor image, counted from frame start at zero.
// RULE5: Host edits go to a staging table and leave corrected pixels unchanged until commit.
// RULE6: Commit copies the staging table into the volatile active table used by correction.
// RULE7: Persist writes the table to non-volatile storage, which is loaded at every power-up.
// RULE8: Factory restore replaces active, stored and staged tables with the factory list.
// RULE9: A commit or restore during streaming may corrupt frames until the copy completes.
// RULE10: Correction applies only while static_correction_on is set, else pixels pass unaltered.
// RULE11: replacement_method selects averaging, highlighting or zeroing of listed pixels.
// RULE12: Averaging uses the mean of neighbours; highlighting forces the largest pixel value.
// RULE13: The host adds an entry by raising the count, selecting it, writing it, then committing.
// RULE14: Only active entries below the active count take part in matching.
// RULE15: A pixel is replaced only when its column and row match an entry exactly.
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

`define DPC_DEPTH 16
`define DPC_IDX_W 4
`define DPC_CNT_W 5
`define DPC_COORD_W 11
`define DPC_PIX_W 12
`define DPC_WORD_W 14
`define DPC_LINE_LEN 2048
`define DPC_PIX_MAX 12'hfff
`define DPC_IDX_LAST 4'hf

`define DPC_METHOD_AVERAGE 2'h0
`define DPC_METHOD_HIGHLIGHT 2'h1
`define DPC_METHOD_ZERO 2'h2

`define DPC_FACTORY_COUNT 5'h02
`define DPC_FACTORY_COL0 11'h010
`define DPC_FACTORY_ROW0 11'h020
`define DPC_FACTORY_COL1 11'h100
`define DPC_FACTORY_ROW1 11'h080

`endif

/* pkg/dpc_pkg.sv */
/*
 * Types shared by the defect pixel table corrector.
 * Assumes dpc_map.svh is on the include path.
 */
`include "dpc_map.svh"
package dpc_pkg;
  typedef logic [`DPC_COORD_W-1:0] coord_t;
  typedef logic [`DPC_PIX_W-1:0] pixel_t;
  typedef logic [`DPC_CNT_W-1:0] count_t;
  typedef logic [`DPC_IDX_W-1:0] index_t;
  typedef enum {ENG_BOOT, ENG_IDLE, ENG_COMMIT, ENG_PERSIST, ENG_FACTORY} engine_state_t;
endpackage

/* pkg/pix_buf_if.sv */
/*
 * Valid/ready carrier between the correction path and its output buffer.
 * Assumes both ends run on one clock.
 */
`timescale 1ns/100ps
interface pix_buf_if #(parameter int W = 14);
  logic s_valid;
  logic s_ready;
  logic [W-1:0] s_data;
  logic m_valid;
  logic m_ready;
  logic [W-1:0] m_data;
  modport filler (output s_valid, output s_data, output m_ready,
                  input s_ready, input m_valid, input m_data);
  modport store (input s_valid, input s_data, input m_ready,
                 output s_ready, output m_valid, output m_data);
endinterface

/* hdl/pix_skid_buffer.sv */
/*
 * Two-entry buffer: a head word that drives the output and one spare.
 * Assumes one clock and a synchronous active-low reset; all outputs are flops.
 */
`timescale 1ns/100ps
module pix_skid_buffer (
  input wire logic sys_clk,
  input wire logic rst_b,
  pix_buf_if.store bus
);
  logic head_valid_reg;
  logic spare_valid_reg;
  logic [$bits(bus.s_data)-1:0] head_reg;
  logic [$bits(bus.s_data)-1:0] spare_reg;
  logic push;
  logic pop;

  assign push = bus.s_valid && !spare_valid_reg;
  assign pop = head_valid_reg && bus.m_ready;
  assign bus.s_ready = !spare_valid_reg;
  assign bus.m_valid = head_valid_reg;
  assign bus.m_data = head_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Spare only fills while the head is stalled, so no word is lost
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      head_valid_reg <= 1'b0;
      spare_valid_reg <= 1'b0;
      head_reg <= '0;
      spare_reg <= '0;
    end else if (!head_valid_reg || pop) begin
      if (spare_valid_reg) begin
        head_reg <= spare_reg;
        head_valid_reg <= 1'b1;
        spare_valid_reg <= 1'b0;
      end else begin
        head_reg <= bus.s_data;
        head_valid_reg <= push;
      end
    end else if (push) begin
      spare_reg <= bus.s_data;
      spare_valid_reg <= 1'b1;
    end
  end
endmodule

/* hdl/defect_pixel_table_correction.sv */
/*
 * Table-driven defective pixel correction with staged, active and stored tables.
 * Assumes control inputs come from logic on sys_clk and the stream carries the full sensor.
 */
`timescale 1ns/100ps
`include "dpc_map.svh"
module defect_pixel_table_correction
  import dpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic static_correction_on,
  input wire logic [1:0] replacement_method,
  input wire logic entry_count_wr,
  input wire logic [`DPC_CNT_W-1:0] entry_count_in,
  input wire logic entry_select_wr,
  input wire logic [`DPC_IDX_W-1:0] entry_select_in,
  input wire logic entry_col_wr,
  input wire logic [`DPC_COORD_W-1:0] entry_col_in,
  input wire logic entry_row_wr,
  input wire logic [`DPC_COORD_W-1:0] entry_row_in,
  input wire logic commit_table,
  input wire logic persist_table,
  input wire logic restore_factory_table,
  output logic [`DPC_CNT_W-1:0] entry_count,
  output logic [`DPC_IDX_W-1:0] entry_select,
  output logic [`DPC_COORD_W-1:0] entry_col,
  output logic [`DPC_COORD_W-1:0] entry_row,
  output logic table_busy,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [`DPC_PIX_W-1:0] in_pixel,
  input wire logic in_sof,
  input wire logic in_eol,
  output logic out_valid,
  input wire logic out_ready,
  output logic [`DPC_PIX_W-1:0] out_pixel,
  output logic out_sof,
  output logic out_eol
);
  coord_t stage_col [`DPC_DEPTH];
  coord_t stage_row [`DPC_DEPTH];
  coord_t act_col [`DPC_DEPTH];
  coord_t act_row [`DPC_DEPTH];
  coord_t store_col [`DPC_DEPTH];
  coord_t store_row [`DPC_DEPTH];
  pixel_t line_mem [`DPC_LINE_LEN];
  count_t stage_count_reg;
  count_t act_count_reg;
  count_t store_count_reg;
  index_t select_reg;
  index_t eng_idx_reg;
  engine_state_t eng_state_reg;
  coord_t col_reg;
  coord_t row_reg;
  pixel_t left_reg;
  coord_t cur_col;
  coord_t cur_row;
  pixel_t above_pix;
  pixel_t fixed_pix;
  logic accept;
  logic defect_hit;
  logic nv_user_reg = 1'b0;
  coord_t boot_col;
  coord_t boot_row;

  pix_buf_if #(.W(`DPC_WORD_W)) obuf ();

  pix_skid_buffer u_obuf (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bus(obuf.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic coord_t factory_col(input index_t i);
    factory_col = (i == 4'h0) ? `DPC_FACTORY_COL0 : (i == 4'h1) ? `DPC_FACTORY_COL1 : '0;
  endfunction

  function automatic coord_t factory_row(input index_t i);
    factory_row = (i == 4'h0) ? `DPC_FACTORY_ROW0 : (i == 4'h1) ? `DPC_FACTORY_ROW1 : '0;
  endfunction

  function automatic pixel_t mean2(input pixel_t a, input pixel_t b);
    logic [`DPC_PIX_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    mean2 = sum[`DPC_PIX_W:1];
  endfunction

  // Stored table survives rst_b; reads as factory list until first persist
  assign boot_col = nv_user_reg ? store_col[eng_idx_reg] : factory_col(eng_idx_reg);
  assign boot_row = nv_user_reg ? store_row[eng_idx_reg] : factory_row(eng_idx_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Table engine: moves one entry per cycle; commands are taken only while idle, and ignored while busy
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      eng_state_reg <= ENG_BOOT;
      eng_idx_reg <= '0;
      act_count_reg <= '0;
      stage_count_reg <= '0;
    end else begin
      case (eng_state_reg)
        ENG_BOOT: begin
          stage_col[eng_idx_reg] <= boot_col; // RULE7
          stage_row[eng_idx_reg] <= boot_row;
          act_col[eng_idx_reg] <= boot_col;
          act_row[eng_idx_reg] <= boot_row;
          eng_idx_reg <= eng_idx_reg + 4'h1;
          if (eng_idx_reg == `DPC_IDX_LAST) begin
            eng_state_reg <= ENG_IDLE;
            act_count_reg <= nv_user_reg ? store_count_reg : `DPC_FACTORY_COUNT;
            stage_count_reg <= nv_user_reg ? store_count_reg : `DPC_FACTORY_COUNT;
          end
        end
        ENG_IDLE: begin
          eng_idx_reg <= '0;
          if (restore_factory_table) begin
            eng_state_reg <= ENG_FACTORY;
          end else if (commit_table) begin
            eng_state_reg <= ENG_COMMIT;
          end else if (persist_table) begin
            eng_state_reg <= ENG_PERSIST;
          end else begin
            if (entry_count_wr && entry_count_in <= count_t'(`DPC_DEPTH)) begin
              stage_count_reg <= entry_count_in; // RULE1 RULE5
            end
            if (entry_col_wr) begin
              stage_col[select_reg] <= entry_col_in; // RULE3 RULE5
            end
            if (entry_row_wr) begin
              stage_row[select_reg] <= entry_row_in; // RULE3 RULE5
            end
          end
        end
        ENG_COMMIT: begin
          act_col[eng_idx_reg] <= stage_col[eng_idx_reg]; // RULE6 RULE9
          act_row[eng_idx_reg] <= stage_row[eng_idx_reg];
          eng_idx_reg <= eng_idx_reg + 4'h1;
          if (eng_idx_reg == `DPC_IDX_LAST) begin
            eng_state_reg <= ENG_IDLE;
            act_count_reg <= stage_count_reg; // RULE6
          end
        end
        ENG_PERSIST: begin
          store_col[eng_idx_reg] <= stage_col[eng_idx_reg]; // RULE7
          store_row[eng_idx_reg] <= stage_row[eng_idx_reg];
          eng_idx_reg <= eng_idx_reg + 4'h1;
          if (eng_idx_reg == `DPC_IDX_LAST) begin
            eng_state_reg <= ENG_IDLE;
            store_count_reg <= stage_count_reg;
            nv_user_reg <= 1'b1; // RULE7
          end
        end
        ENG_FACTORY: begin
          act_col[eng_idx_reg] <= factory_col(eng_idx_reg); // RULE8 RULE9
          act_row[eng_idx_reg] <= factory_row(eng_idx_reg);
          store_col[eng_idx_reg] <= factory_col(eng_idx_reg);
          store_row[eng_idx_reg] <= factory_row(eng_idx_reg);
          stage_col[eng_idx_reg] <= factory_col(eng_idx_reg);
          stage_row[eng_idx_reg] <= factory_row(eng_idx_reg);
          eng_idx_reg <= eng_idx_reg + 4'h1;
          if (eng_idx_reg == `DPC_IDX_LAST) begin
            eng_state_reg <= ENG_IDLE;
            act_count_reg <= `DPC_FACTORY_COUNT; // RULE8
            store_count_reg <= `DPC_FACTORY_COUNT;
            stage_count_reg <= `DPC_FACTORY_COUNT;
          end
        end
        default: begin
          eng_state_reg <= ENG_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host view of the staged table
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      select_reg <= '0;
    end else if (entry_select_wr) begin
      select_reg <= entry_select_in; // RULE2
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      entry_count <= '0;
      entry_select <= '0;
      entry_col <= '0;
      entry_row <= '0;
      table_busy <= 1'b1;
    end else begin
      entry_count <= stage_count_reg; // RULE1
      entry_select <= select_reg;
      entry_col <= stage_col[select_reg]; // RULE3
      entry_row <= stage_row[select_reg];
      table_busy <= eng_state_reg != ENG_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position of the incoming pixel in the full sensor frame
  assign accept = in_valid && obuf.s_ready;
  assign cur_col = in_sof ? '0 : col_reg; // RULE4
  assign cur_row = in_sof ? '0 : row_reg;
  assign above_pix = line_mem[cur_col];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      col_reg <= '0;
      row_reg <= '0;
      left_reg <= '0;
    end else if (accept) begin
      left_reg <= in_pixel;
      line_mem[cur_col] <= in_pixel;
      if (in_eol) begin
        col_reg <= '0;
        row_reg <= cur_row + 11'h001;
      end else begin
        col_reg <= cur_col + 11'h001;
        row_reg <= cur_row;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel compare; stale entries beyond the active count never match
  always_comb begin
    defect_hit = 1'b0;
    for (int i = 0; i < `DPC_DEPTH; i++) begin
      if (count_t'(i) < act_count_reg // RULE14
          && act_col[i] == cur_col && act_row[i] == cur_row) begin
        defect_hit = 1'b1; // RULE15
      end
    end
  end

  // Average uses only causal neighbours (left, above) to avoid a look-ahead stage
  always_comb begin
    fixed_pix = in_pixel;
    if (static_correction_on && defect_hit) begin // RULE10
      case (replacement_method) // RULE11
        `DPC_METHOD_AVERAGE: begin
          if (cur_col != '0 && cur_row != '0) begin
            fixed_pix = mean2(left_reg, above_pix); // RULE12
          end else if (cur_col != '0) begin
            fixed_pix = left_reg;
          end else if (cur_row != '0) begin
            fixed_pix = above_pix;
          end else begin
            fixed_pix = in_pixel;
          end
        end
        `DPC_METHOD_HIGHLIGHT: fixed_pix = `DPC_PIX_MAX; // RULE12
        `DPC_METHOD_ZERO: fixed_pix = '0;
        default: fixed_pix = in_pixel;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign obuf.s_valid = in_valid;
  assign obuf.s_data = {in_sof, in_eol, fixed_pix};
  assign obuf.m_ready = out_ready;
  assign in_ready = obuf.s_ready;
  assign out_valid = obuf.m_valid;
  assign out_sof = obuf.m_data[`DPC_WORD_W-1];
  assign out_eol = obuf.m_data[`DPC_WORD_W-2];
  assign out_pixel = obuf.m_data[`DPC_PIX_W-1:0];
endmodule

/* bench/dpc_sink.sv */
/*
 * Downstream sink model: accepts words from the corrector, stalling on request.
 * Assumes the bench raises stall only while it wants the buffer to fill.
 */
`timescale 1ns/100ps
module dpc_sink (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic stall,
  output logic out_ready
);
  logic [1:0] phase_reg;
  // Three idle cycles in four, so the buffer really refuses input
  always_ff @(posedge sys_clk) begin
    phase_reg <= rst_b ? phase_reg + 2'h1 : 2'h0;
    out_ready <= rst_b && (!stall || phase_reg == 2'h0);
  end
endmodule

/* bench/dpc_chk.sv */
/*
 * Port checker of the corrector: copy engine timing, read-backs, stream hold.
 * Assumes dpc_map.svh is on the include path; the bind stands at the foot.
 */
`timescale 1ns/100ps
`include "dpc_map.svh"
module dpc_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic commit_table,
  input wire logic persist_table,
  input wire logic restore_factory_table,
  input wire logic entry_count_wr,
  input wire logic entry_select_wr,
  input wire logic [`DPC_IDX_W-1:0] entry_select_in,
  input wire logic [`DPC_CNT_W-1:0] entry_count,
  input wire logic [`DPC_IDX_W-1:0] entry_select,
  input wire logic table_busy,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [`DPC_PIX_W-1:0] out_pixel,
  input wire logic out_sof,
  input wire logic out_eol
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_cmd;
    (commit_table || persist_table || restore_factory_table) && !table_busy && !$past(table_busy);
  endsequence
  sequence s_copy;
    ##2 table_busy [*8];
  endsequence
  property p_cmd_busy;
    s_cmd |-> s_copy;
  endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("copy did not start");
  property p_busy_len;
    $rose(table_busy) |-> table_busy [*8] ##[7:10] !table_busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("copy length wrong");
  property p_sel;
    entry_select_wr && !table_busy && !$past(table_busy) && !commit_table && !persist_table
      && !restore_factory_table |-> ##2 entry_select == $past(entry_select_in, 2);
  endproperty
  a_sel: assert property (p_sel) else $error("select not taken");
  property p_cnt;
    $changed(entry_count) |-> $past(entry_count_wr) || $past(entry_count_wr, 2)
      || $past(table_busy);
  endproperty
  a_cnt: assert property (p_cnt) else $error("count changed uncaused");
  property p_cnt_max;
    entry_count <= 5'h10;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("count above depth");
  // Stalled word must not slip, or the receiver loses it
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_pixel) && $stable(out_sof)
      && $stable(out_eol);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");
  property p_lat;
    in_valid && in_ready && !out_valid |=> out_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("word late at output");
  property p_ready;
    !in_ready |-> out_valid;
  endproperty
  a_ready: assert property (p_ready) else $error("refused while empty");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind defect_pixel_table_correction dpc_chk dpc_chk_inst (.sys_clk, .rst_b, .commit_table,
  .persist_table, .restore_factory_table, .entry_count_wr, .entry_select_wr, .entry_select_in,
  .entry_count, .entry_select, .table_busy, .in_valid, .in_ready, .out_valid, .out_ready,
  .out_pixel, .out_sof, .out_eol);

/* bench/tb.sv */
/*
 * Bench: host table edits and a short-line stream through the corrector.
 * Assumes package, map header, buffer, design and sink model compile first.
 */
`timescale 1ns/100ps
`include "dpc_map.svh"
module tb;
  import dpc_pkg::*;
  logic sys_clk = 1'h0, rst_b = 1'h0, static_correction_on = 1'h0, entry_count_wr = 1'h0;
  logic entry_select_wr = 1'h0, entry_col_wr = 1'h0, entry_row_wr = 1'h0, in_eol = 1'h0;
  logic commit_table = 1'h0, persist_table = 1'h0, restore_factory_table = 1'h0;
  logic in_valid = 1'h0, in_sof = 1'h0, stall = 1'h0;
  logic [1:0] replacement_method = '0;
  count_t entry_count_in = '0, entry_count;
  index_t entry_select_in = '0, entry_select;
  coord_t entry_col_in = '0, entry_row_in = '0, entry_col, entry_row;
  pixel_t in_pixel = '0, out_pixel, p[2][8];
  logic [13:0] q[$];
  logic table_busy, in_ready, out_valid, out_ready, out_sof, out_eol;
  int error_cnt = 0, comparisons = 0, tests = 0;
  logic [16:0] seed = 17'h11060;
  always #20 sys_clk = ~sys_clk;
  defect_pixel_table_correction defect_pixel_table_correction_inst (.sys_clk, .rst_b,
    .static_correction_on, .replacement_method, .entry_count_wr, .entry_count_in,
    .entry_select_wr, .entry_select_in, .entry_col_wr, .entry_col_in, .entry_row_wr,
    .entry_row_in, .commit_table, .persist_table, .restore_factory_table, .entry_count,
    .entry_select, .entry_col, .entry_row, .table_busy, .in_valid, .in_ready, .in_pixel,
    .in_sof, .in_eol, .out_valid, .out_ready, .out_pixel, .out_sof, .out_eol);
  dpc_sink dpc_sink_inst (.sys_clk, .rst_b, .stall, .out_ready);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic idle;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 40 && table_busy !== 1'h0; i++) @(posedge sys_clk);
    check(table_busy, 16'h0);
  endtask
  task automatic wr(input logic [3:0] k, input count_t n, input index_t s, input coord_t c,
                    input coord_t r);
    @(posedge sys_clk);
    {entry_count_wr, entry_select_wr, entry_col_wr, entry_row_wr} <= k;
    {entry_count_in, entry_select_in, entry_col_in, entry_row_in} <= {n, s, c, r};
    @(posedge sys_clk);
    {entry_count_wr, entry_select_wr, entry_col_wr, entry_row_wr} <= 4'h0;
  endtask
  task automatic go(input logic [2:0] k);
    @(posedge sys_clk);
    {commit_table, persist_table, restore_factory_table} <= k;
    @(posedge sys_clk);
    {commit_table, persist_table, restore_factory_table} <= 3'h0;
    idle();
  endtask
  task automatic reboot;
    @(posedge sys_clk);
    rst_b <= 1'h0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'h1;
    idle();
  endtask
  // Two lines of eight; pixel (3,1) is the only listed one inside the frame
  task automatic frame(input logic hit);
    pixel_t v, e;
    for (int r = 0; r < 2; r++) for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      v = {1'h0, seed[10:1], 1'h0};
      p[r][c] = v;
      e = v;
      if (hit && r == 1 && c == 3) begin
        case (replacement_method)
          2'h0: e = (p[1][2] + p[0][3]) >> 1;
          2'h1: e = `DPC_PIX_MAX;
          2'h2: e = 12'h000;
          default: e = v;
        endcase
      end
      q.push_back({r == 0 && c == 0, c == 7, e});
      @(posedge sys_clk);
      {in_valid, in_pixel, in_sof, in_eol} <= {1'h1, v, r == 0 && c == 0, c == 7};
      do @(posedge sys_clk); while (in_ready !== 1'h1);
      in_valid <= 1'h0;
    end
    for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge sys_clk);
    check(16'(q.size()), 16'h0);
    tests++;
    $display("test %0d done", tests);
  endtask
  always @(posedge sys_clk) begin
    if (out_valid === 1'h1 && out_ready === 1'h1) begin
      check({out_sof, out_eol, out_pixel}, q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'h1;
    idle();
    check(entry_count, `DPC_FACTORY_COUNT);
    stall <= 1'h1;
    static_correction_on <= 1'h1;
    wr(4'h8, 5'h03, 4'h0, '0, '0);
    wr(4'h4, 5'h03, 4'h2, '0, '0);
    wr(4'h3, 5'h03, 4'h2, 11'h003, 11'h001);
    repeat (2) @(posedge sys_clk);
    check(entry_count, 16'h3);
    check(entry_select, 16'h2);
    check(entry_col, 16'h3);
    check(entry_row, 16'h1);
    frame(1'h0);
    go(3'h4);
    for (int m = 0; m < 4; m++) begin
      replacement_method <= m[1:0];
      frame(1'h1);
    end
    // Highlight, so a wrong hit in later frames shows up
    replacement_method <= 2'h1;
    static_correction_on <= 1'h0;
    frame(1'h0);
    static_correction_on <= 1'h1;
    wr(4'h8, 5'h02, 4'h0, '0, '0);
    go(3'h4);
    frame(1'h0);
    wr(4'h8, 5'h03, 4'h0, '0, '0);
    go(3'h2);
    reboot();
    check(entry_count, 16'h3);
    frame(1'h1);
    go(3'h1);
    check(entry_count, `DPC_FACTORY_COUNT);
    frame(1'h0);
    reboot();
    check(entry_count, `DPC_FACTORY_COUNT);
    end_of_test();
  end
  // About ten stalled frames and a few copies fit well inside this span
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end
endmodule
